// *** logic/dxe_core.sv ***
// dsp execute core: three-stage pipeline, data memories and axi4-lite slave
// What this block does
// - loop count set loads 8-bit unsigned literal
// - short literal accumulator load sign-extends
// - short literal pointer load zero-extends
// - mult load clear loads operands, clears accumulator
// - load only, accumulate, accumulate negative forms
// - conditional negate, double word option
// - or acts on accumulator high word
// - push and pop registers, literals, bank
// - immediate repeat runs next n+1 times
// - register or memory repeat runs value+1
// - bit clear, set, flip one bit
// - bit probe tests without modifying
// - irq enable set; sleep halts, optional enable
// - immediate shift by signed 6-bit amount
// - conditional shift by leading bit count
// - conditional swap of accumulator halves
// - subtract many sources, optional carry
// - direct address 8 bits, bank select
// - long literal is full 16-bit extension
// - short literal is 10 bits
// - branch target is 16-bit code address
// - false predicate performs no update
// - every operand load forms 16x16 product
// - two's complement fractional arithmetic
// - fetch, decode, execute pipeline
//
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
module dxe_core (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address and data
  input  wire logic [12:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [12:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // core state
  output logic             irq_enable,
  output logic             sleeping
);
  import dxe_pkg::*;

  logic [31:0] pmem [PMEM_DEPTH];
  logic [15:0] xmem [DMEM_DEPTH];
  logic [15:0] ymem [DMEM_DEPTH];
  logic [15:0] pc_q;
  logic [31:0] f_ir_q, d_ir_q;
  logic        f_v_q, d_v_q;
  logic [39:0] acc_q, acc_d;
  logic [15:0] x_q, x_d, y_q, y_d, px_q, px_d, py_q, py_d, exp_q, exp_d, rep_q, rep_d;
  logic [31:0] prod_q, prod_d;
  logic [7:0]  lc0_q, lc0_d, lc1_q, lc1_d;
  logic [8:0]  sp_q, sp_d;
  logic        z_q, z_d, n_q, n_d, c_q, c_d, ie_q, ie_d, slp_q, slp_d, run_q;
  logic        br_take, m_we, m_bank, rep_hold, exec_en, advance;
  logic [8:0]  m_addr;
  logic [15:0] m_wd;
  logic [12:0] aw_a_q;
  logic [31:0] w_d_q;
  logic [3:0]  w_s_q;
  logic        aw_full_q, w_full_q, wr_go;
  dxe_rgn_e    wr_rgn, rd_rgn;

  // decoded fields of the instruction in execute
  dxe_op_e     op;
  dxe_src_e    src;
  logic [3:0]  sel;
  logic        opt_a, opt_b, bank;
  logic [15:0] limm, short_literal_z, short_literal_s, ptr_rd, src_v, bit_v, mask;
  assign op     = dxe_op_e'(d_ir_q[31:F_OP_LO]);
  assign src    = dxe_src_e'(d_ir_q[F_SRC_LO+2:F_SRC_LO]);
  assign sel    = d_ir_q[F_SEL_LO+3:F_SEL_LO];
  assign opt_a  = d_ir_q[F_OPT_A];
  assign opt_b  = d_ir_q[F_OPT_B];
  assign bank   = d_ir_q[F_BANK];
  assign limm   = d_ir_q[LIMM_W-1:0];
  assign short_literal_z = {{(16-SHORT_LITERAL_W){1'b0}}, d_ir_q[SHORT_LITERAL_W-1:0]};
  assign short_literal_s = {{(16-SHORT_LITERAL_W){d_ir_q[SHORT_LITERAL_W-1]}}, d_ir_q[SHORT_LITERAL_W-1:0]};
  assign ptr_rd = bank ? ymem[py_q[8:0]] : xmem[px_q[8:0]];
  assign mask   = 16'h0001 << d_ir_q[3:0];

  // status predicate; code 0 always true
  function automatic logic cond_ok(input logic [3:0] cc);
    unique case (cc)
      4'h0: cond_ok = 1'b1;
      4'h1: cond_ok = z_q;
      4'h2: cond_ok = ~z_q;
      4'h3: cond_ok = n_q;
      4'h4: cond_ok = ~n_q;
      4'h5: cond_ok = c_q;
      4'h6: cond_ok = ~c_q;
      default: cond_ok = 1'b0;
    endcase
  endfunction

  function automatic logic [15:0] rd_reg(input logic [3:0] s);
    unique case (s)
      DR_AL:   rd_reg = acc_q[15:0];
      DR_AH:   rd_reg = acc_q[31:16];
      DR_X:    rd_reg = x_q;
      DR_Y:    rd_reg = y_q;
      DR_ST:   rd_reg = {13'h0000, c_q, n_q, z_q};
      DR_PL:   rd_reg = prod_q[15:0];
      DR_PH:   rd_reg = prod_q[31:16];
      DR_EXP:  rd_reg = exp_q;
      DR_AG:   rd_reg = {{8{acc_q[39]}}, acc_q[39:32]};
      default: rd_reg = 16'h0000;
    endcase
  endfunction

  function automatic logic [15:0] rd_rc(input logic [1:0] s);
    unique case (s)
      2'b00: rd_rc = px_q;
      2'b01: rd_rc = py_q;
      2'b10: rd_rc = {8'h00, lc0_q};
      2'b11: rd_rc = {8'h00, lc1_q};
    endcase
  endfunction

  // fractional product: 16x16 signed, doubled to drop the redundant sign
  function automatic logic [31:0] fmul(input logic [15:0] a, input logic [15:0] b);
    logic signed [31:0] p;
    p = $signed(a) * $signed(b);
    fmul = {p[30:0], 1'b0};
  endfunction

  function automatic logic [39:0] shifter(input logic [39:0] a, input logic right, input logic [5:0] cnt);
    shifter = right ? 40'($signed(a) >>> cnt) : (a << cnt);
  endfunction

  function automatic dxe_rgn_e dec_rgn(input logic [12:0] a);
    if (a[12:5] == 8'h00 && a[4:2] <= ADDR_PROD[4:2]) begin
      dec_rgn = RG_CSR;
    end else if (a[12:8] == PMEM_BASE[12:8]) begin
      dec_rgn = RG_PMEM;
    end else if (a[12:11] == XMEM_BASE[12:11]) begin
      dec_rgn = RG_XMEM;
    end else if (a[12:11] == YMEM_BASE[12:11]) begin
      dec_rgn = RG_YMEM;
    end else begin
      dec_rgn = RG_NONE;
    end
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] v, input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = s[i] ? v[8*i +: 8] : o[8*i +: 8];
    end
  endfunction

  // pipeline control; repeat holds the repeated instruction in execute
  assign exec_en  = d_v_q & run_q & ~slp_q;
  assign rep_hold = exec_en & (rep_q != 16'h0000) & (op != OP_REP);
  assign advance  = run_q & ~slp_q & ~rep_hold;

  // execute stage: all architectural next values except the pc
  always_comb begin
    logic [39:0] p40, o40;
    logic [40:0] diff;
    logic [15:0] xo, yo, wv;
    logic        rwe, cwe;
    logic [3:0]  rws;
    p40 = {{8{prod_q[31]}}, prod_q};
    o40 = 40'h0000000000;
    diff = 41'h00000000000;
    xo = 16'h0000;
    yo = 16'h0000;
    wv = 16'h0000;
    rwe = 1'b0;
    cwe = 1'b0;
    rws = sel;
    acc_d = acc_q; x_d = x_q; y_d = y_q; prod_d = prod_q;
    px_d = px_q; py_d = py_q; exp_d = exp_q; lc0_d = lc0_q; lc1_d = lc1_q;
    sp_d = sp_q; z_d = z_q; n_d = n_q; c_d = c_q; ie_d = ie_q; slp_d = slp_q;
    rep_d = rep_hold ? rep_q - 16'h0001 : rep_q;
    br_take = 1'b0;
    m_we = 1'b0;
    m_bank = bank;
    m_addr = bank ? py_q[8:0] : px_q[8:0];
    m_wd = 16'h0000;
    // operand source for or and subtract
    unique case (src)
      SRC_REG:  src_v = rd_reg(sel);
      SRC_MEM:  src_v = ptr_rd;
      SRC_DRAM: src_v = bank ? ymem[{1'b0, d_ir_q[DRAM_W-1:0]}] : xmem[{1'b0, d_ir_q[DRAM_W-1:0]}];
      SRC_PMEM: src_v = pmem[px_q[5:0]][15:0];
      SRC_RC:   src_v = rd_rc(d_ir_q[1:0]);
      SRC_IMM:  src_v = limm;
      SRC_SHORT_LITERAL: src_v = (op == OP_SUB) ? short_literal_s : short_literal_z;
      default:  src_v = 16'h0000;
    endcase
    bit_v = opt_b ? ptr_rd : rd_reg(sel);
    if (exec_en) begin
      unique case (op)
        OP_LD_LC: begin
          if (opt_a) lc1_d = d_ir_q[LC_W-1:0];
          else lc0_d = d_ir_q[LC_W-1:0];
        end
        OP_SHORT_LITERAL_LOAD_A: acc_d = {{8{short_literal_s[15]}}, short_literal_s, 16'h0000};
        OP_SHORT_LITERAL_LOAD_P: begin
          if (bank) py_d = short_literal_z;
          else px_d = short_literal_z;
        end
        OP_MLD, OP_MULT_ACCUMULATE, OP_MULT_SUBTRACT, OP_MULT_LOAD_ONLY: begin
          xo = xmem[px_q[8:0]];
          yo = opt_a ? xo : (opt_b ? rd_reg(sel) : ymem[py_q[8:0]]);
          x_d = xo;
          y_d = yo;
          prod_d = fmul(xo, yo);
          if (op == OP_MLD) acc_d = 40'h0000000000;
          else if (op == OP_MULT_ACCUMULATE) acc_d = acc_q + p40;
          else if (op == OP_MULT_SUBTRACT) acc_d = acc_q - p40;
        end
        OP_NEG: if (cond_ok(sel)) begin
          if (opt_a) acc_d = 40'h0000000000 - acc_q;
          else acc_d = {24'h000000 - acc_q[39:16], acc_q[15:0]};
        end
        OP_OR: acc_d[31:16] = acc_q[31:16] | src_v;
        OP_PUSH: begin
          sp_d = sp_q - 9'h001;
          m_we = 1'b1;
          m_addr = sp_q - 9'h001;
          m_wd = opt_b ? rd_rc(d_ir_q[1:0]) : (src == SRC_IMM ? limm : rd_reg(sel));
        end
        OP_POP: begin
          sp_d = sp_q + 9'h001;
          wv = bank ? ymem[sp_q] : xmem[sp_q];
          cwe = opt_b;
          rwe = ~opt_b;
        end
        OP_REP: begin
          if (src == SRC_REG) rep_d = rd_reg(sel);
          else if (src == SRC_MEM) rep_d = ptr_rd;
          else rep_d = {7'h00, d_ir_q[REP_W-1:0]};
        end
        OP_BCLR, OP_BSET, OP_BFLIP: begin
          if (op == OP_BCLR) wv = bit_v & ~mask;
          else if (op == OP_BSET) wv = bit_v | mask;
          else wv = bit_v ^ mask;
          m_we = opt_b;
          m_wd = wv;
          rwe = ~opt_b;
        end
        OP_BPROBE: z_d = ~|(bit_v & mask);
        OP_SETIE: ie_d = 1'b1;
        OP_SLEEP: begin
          slp_d = 1'b1;
          if (opt_a) ie_d = 1'b1;
        end
        OP_BARREL_SHIFT_I: begin
          if (d_ir_q[SHIFT_W-1]) acc_d = shifter(acc_q, 1'b1, 6'h00 - d_ir_q[5:0]);
          else acc_d = shifter(acc_q, 1'b0, d_ir_q[5:0]);
        end
        OP_BARREL_SHIFT_R: if (cond_ok(sel)) acc_d = shifter(acc_q, opt_a, exp_q[5:0]);
        OP_SWAP: if (cond_ok(sel)) acc_d = {acc_q[39:32], acc_q[15:0], acc_q[31:16]};
        OP_SUB: begin
          o40 = {{8{src_v[15]}}, src_v, 16'h0000};
          diff = {1'b0, acc_q} - {1'b0, o40} - {40'h0000000000, opt_a & c_q};
          acc_d = diff[39:0];
          c_d = diff[40];
        end
        OP_BRA: br_take = cond_ok(sel);
        default: ;
      endcase
      // flags follow accumulator changes made by the operation, not register writes by pop or bit ops
      if (acc_d != acc_q) begin
        z_d = (acc_d == 40'h0000000000);
        n_d = acc_d[39];
      end
      if (rwe) begin
        unique case (rws)
          DR_AL:   acc_d[15:0] = wv;
          DR_AH:   acc_d[31:16] = wv;
          DR_X:    x_d = wv;
          DR_Y:    y_d = wv;
          DR_ST:   {c_d, n_d, z_d} = wv[2:0];
          DR_PL:   prod_d[15:0] = wv;
          DR_PH:   prod_d[31:16] = wv;
          DR_EXP:  exp_d = wv;
          DR_AG:   acc_d[39:32] = wv[7:0];
          default: ;
        endcase
      end
      if (cwe) begin
        unique case (d_ir_q[1:0])
          2'b00: px_d = wv;
          2'b01: py_d = wv;
          2'b10: lc0_d = wv[7:0];
          2'b11: lc1_d = wv[7:0];
        endcase
      end
    end
    // software wake, but a sleep in the same cycle wins
    if (wr_go && wr_rgn == RG_CSR && aw_a_q[4:2] == ADDR_CTRL[4:2] && w_s_q[0] && w_d_q[CTRL_WAKE] &&
        !(exec_en && op == OP_SLEEP)) begin
      slp_d = 1'b0;
    end
  end

  // architectural registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_q <= 40'h0000000000; x_q <= 16'h0000; y_q <= 16'h0000; prod_q <= 32'h00000000;
      px_q <= 16'h0000; py_q <= 16'h0000; exp_q <= 16'h0000; rep_q <= 16'h0000;
      lc0_q <= 8'h00; lc1_q <= 8'h00; sp_q <= SP_RESET;
      z_q <= 1'b0; n_q <= 1'b0; c_q <= 1'b0; ie_q <= 1'b0; slp_q <= 1'b0;
    end else begin
      acc_q <= acc_d; x_q <= x_d; y_q <= y_d; prod_q <= prod_d;
      px_q <= px_d; py_q <= py_d; exp_q <= exp_d; rep_q <= rep_d;
      lc0_q <= lc0_d; lc1_q <= lc1_d; sp_q <= sp_d;
      z_q <= z_d; n_q <= n_d; c_q <= c_d; ie_q <= ie_d; slp_q <= slp_d;
    end
  end

  // fetch and decode stages; a taken branch flushes both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_q <= PC_RESET; f_ir_q <= 32'h00000000; d_ir_q <= 32'h00000000;
      f_v_q <= 1'b0; d_v_q <= 1'b0;
    end else if (br_take) begin
      pc_q <= limm;
      f_v_q <= 1'b0;
      d_v_q <= 1'b0;
    end else if (advance) begin
      f_ir_q <= pmem[pc_q[5:0]];
      f_v_q <= 1'b1;
      pc_q <= pc_q + 16'h0001;
      d_ir_q <= f_ir_q;
      d_v_q <= f_v_q;
    end
  end

  // memories: core writes first; bus writes only land while stopped
  always_ff @(posedge aclk) begin
    if (m_we) begin
      if (m_bank) ymem[m_addr] <= m_wd;
      else xmem[m_addr] <= m_wd;
    end else if (wr_go && !run_q) begin
      unique case (wr_rgn)
        RG_PMEM: pmem[aw_a_q[7:2]] <= merge(pmem[aw_a_q[7:2]], w_d_q, w_s_q);
        RG_XMEM: xmem[aw_a_q[10:2]] <= 16'(merge({16'h0000, xmem[aw_a_q[10:2]]}, w_d_q, w_s_q));
        RG_YMEM: ymem[aw_a_q[10:2]] <= 16'(merge({16'h0000, ymem[aw_a_q[10:2]]}, w_d_q, w_s_q));
        default: ;
      endcase
    end
  end

  // axi write channel: hold address and data, answer once both are in
  assign wr_go  = aw_full_q & w_full_q & ~s_axi_bvalid;
  assign wr_rgn = dec_rgn(aw_a_q);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0; w_full_q <= 1'b0; aw_a_q <= 13'h0000; w_d_q <= 32'h00000000; w_s_q <= 4'h0;
      s_axi_awready <= 1'b1; s_axi_wready <= 1'b1; s_axi_bvalid <= 1'b0; s_axi_bresp <= RESP_OKAY;
      run_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1; aw_a_q <= s_axi_awaddr; s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1; w_d_q <= s_axi_wdata; w_s_q <= s_axi_wstrb; s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_rgn == RG_NONE) ? RESP_SLVERR : RESP_OKAY;
        if (wr_rgn == RG_CSR && aw_a_q[4:2] == ADDR_CTRL[4:2] && w_s_q[0]) run_q <= w_d_q[CTRL_RUN];
      end
      // ready again only after the answer is taken, one write at a time
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0; s_axi_awready <= 1'b1; s_axi_wready <= 1'b1;
      end
    end
  end

  // axi read channel: one cycle from address to data
  assign rd_rgn = dec_rgn(s_axi_araddr);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1; s_axi_rvalid <= 1'b0; s_axi_rdata <= 32'h00000000; s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= (rd_rgn == RG_NONE) ? RESP_SLVERR : RESP_OKAY;
      unique case (rd_rgn)
        RG_CSR: begin
          unique case (s_axi_araddr[4:2])
            ADDR_CTRL[4:2]:   s_axi_rdata <= {31'h00000000, run_q};
            ADDR_STATUS[4:2]: s_axi_rdata <= {pc_q, 11'h000, c_q, n_q, z_q, ie_q, slp_q};
            ADDR_ACC_HI[4:2]: s_axi_rdata <= {8'h00, acc_q[39:16]};
            ADDR_ACC_LO[4:2]: s_axi_rdata <= {16'h0000, acc_q[15:0]};
            default:          s_axi_rdata <= prod_q;
          endcase
        end
        RG_PMEM: s_axi_rdata <= pmem[s_axi_araddr[7:2]];
        RG_XMEM: s_axi_rdata <= {16'h0000, xmem[s_axi_araddr[10:2]]};
        RG_YMEM: s_axi_rdata <= {16'h0000, ymem[s_axi_araddr[10:2]]};
        default: s_axi_rdata <= 32'h00000000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // status pins straight from flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_enable <= 1'b0;
      sleeping <= 1'b0;
    end else begin
      irq_enable <= ie_d;
      sleeping <= slp_d;
    end
  end
endmodule

// *** logic/dxe_pkg.sv ***
// constants, encodings and register map of the dsp execute core
package dxe_pkg;
  // register map, byte addresses on the 32-bit bus
  localparam logic [12:0] ADDR_CTRL   = 13'h0000;
  localparam logic [12:0] ADDR_STATUS = 13'h0004;
  localparam logic [12:0] ADDR_ACC_HI = 13'h0008;
  localparam logic [12:0] ADDR_ACC_LO = 13'h000C;
  localparam logic [12:0] ADDR_PROD   = 13'h0010;
  localparam logic [12:0] PMEM_BASE   = 13'h0400;
  localparam logic [12:0] XMEM_BASE   = 13'h0800;
  localparam logic [12:0] YMEM_BASE   = 13'h1000;
  localparam int unsigned PMEM_DEPTH  = 64;
  localparam int unsigned DMEM_DEPTH  = 512;
  // control and status bit positions
  localparam int unsigned CTRL_RUN    = 0;
  localparam int unsigned CTRL_WAKE   = 1;
  localparam int unsigned ST_SLEEP    = 0;
  localparam int unsigned ST_IE       = 1;
  localparam int unsigned ST_Z        = 2;
  localparam int unsigned ST_N        = 3;
  localparam int unsigned ST_C        = 4;
  localparam int unsigned ST_PC_LO    = 16;
  // instruction fields
  localparam int unsigned F_OP_LO     = 27;
  localparam int unsigned F_OPT_A     = 26;
  localparam int unsigned F_OPT_B     = 25;
  localparam int unsigned F_SRC_LO    = 22;
  localparam int unsigned F_SEL_LO    = 18;
  localparam int unsigned F_BANK      = 17;
  localparam int unsigned SHORT_LITERAL_W      = 10;
  localparam int unsigned LIMM_W      = 16;
  localparam int unsigned DRAM_W      = 8;
  localparam int unsigned CODE_ADDR_W = 16;
  localparam int unsigned REP_W       = 9;
  localparam int unsigned SHIFT_W     = 6;
  localparam int unsigned LC_W        = 8;
  // reset values and bus answers
  localparam logic [8:0]  SP_RESET    = 9'h000;
  localparam logic [15:0] PC_RESET    = 16'h0000;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  typedef enum logic [4:0] {
    OP_NOP = 5'b00000, OP_LD_LC = 5'b00001, OP_SHORT_LITERAL_LOAD_A = 5'b00010, OP_SHORT_LITERAL_LOAD_P = 5'b00011,
    OP_MLD = 5'b00100, OP_MULT_ACCUMULATE = 5'b00101, OP_MULT_SUBTRACT = 5'b00110, OP_MULT_LOAD_ONLY = 5'b00111,
    OP_NEG = 5'b01000, OP_OR = 5'b01001, OP_PUSH = 5'b01010, OP_POP = 5'b01011,
    OP_REP = 5'b01100, OP_BCLR = 5'b01101, OP_BSET = 5'b01110, OP_BFLIP = 5'b01111,
    OP_BPROBE = 5'b10000, OP_SETIE = 5'b10001, OP_SLEEP = 5'b10010, OP_BARREL_SHIFT_I = 5'b10011,
    OP_BARREL_SHIFT_R = 5'b10100, OP_SWAP = 5'b10101, OP_SUB = 5'b10110, OP_BRA = 5'b10111
  } dxe_op_e;
  typedef enum logic [2:0] {
    SRC_REG = 3'b000, SRC_MEM = 3'b001, SRC_DRAM = 3'b010, SRC_PMEM = 3'b011,
    SRC_RC = 3'b100, SRC_IMM = 3'b101, SRC_SHORT_LITERAL = 3'b110
  } dxe_src_e;
  typedef enum logic [3:0] {
    DR_AL = 4'b0000, DR_AH = 4'b0001, DR_X = 4'b0010, DR_Y = 4'b0011, DR_ST = 4'b0100,
    DR_PL = 4'b0101, DR_PH = 4'b0110, DR_EXP = 4'b0111, DR_AG = 4'b1000
  } dxe_dreg_e;
  typedef enum logic [2:0] {
    RG_CSR = 3'b000, RG_PMEM = 3'b001, RG_XMEM = 3'b010, RG_YMEM = 3'b011, RG_NONE = 3'b100
  } dxe_rgn_e;
endpackage

// *** sim/dsp_core_instruction_exec_tb_top.sv ***
// self-checking testbench of the execute core
module dsp_core_instruction_exec_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import dxe_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq_enable, sleeping, hang;
  logic [12:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, got;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_rresp, s_axi_bresp, rs;
  logic [31:0] pq[$];
  int          err_count, n_compared;

  dxe_core uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_enable, .sleeping);
  dxe_axi_host host (.aclk, .s_axi_awaddr, .s_axi_araddr, .s_axi_wdata, .s_axi_wstrb, .s_axi_awvalid,
    .s_axi_wvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_rready, .hang, .s_axi_awready, .s_axi_wready,
    .s_axi_bvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp);

  // 25 mhz clock
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // a stuck bus ends the run
  always @(posedge aclk) if (hang === 1'b1) begin
    err_count++;
    print_verdict();
  end

  task automatic print_verdict();
    if (err_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [31:0] ins(dxe_op_e o, logic [1:0] ab, dxe_src_e s, logic [3:0] r, logic [15:0] e);
    return {o, ab, s, r, 2'b00, e};
  endfunction
  // reset, preload one x word and the program, run until sleep
  task automatic run(input int xa, input logic [15:0] xd);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    host.wr(XMEM_BASE + 13'(4 * xa), {16'h0000, xd});
    foreach (pq[i]) host.wr(PMEM_BASE + 13'(4 * i), pq[i]);
    host.wr(ADDR_CTRL, 32'h0000_0001);
    repeat (100) begin
      @(posedge aclk);
      if (sleeping === 1'b1) return;
    end
    err_count++;
    print_verdict();
  endtask

  task automatic s_acc();
    pq = '{ins(OP_SHORT_LITERAL_LOAD_A, 0, SRC_SHORT_LITERAL, 0, 16'h0200), ins(OP_OR, 0, SRC_SHORT_LITERAL, 0, 16'h0005),
      ins(OP_NEG, 0, SRC_REG, 4'h1, 0), ins(OP_NEG, 0, SRC_REG, 0, 0), ins(OP_SLEEP, 2'b10, SRC_REG, 0, 0)};
    run(0, 16'h0000);
    host.rd(ADDR_ACC_HI, got, rs);
    check("acc_hi", 32'h0000_01FB, got);
    check("irq_enable", 32'h1, irq_enable);
    host.rd(13'h0014, got, rs);
    check("unmapped_resp", RESP_SLVERR, rs);
    host.wr(13'h0014, 32'h0000_0000);
    check("unmapped_bresp", RESP_SLVERR, s_axi_bresp);
  endtask
  task automatic s_sub();
    pq = '{ins(OP_SHORT_LITERAL_LOAD_A, 0, SRC_SHORT_LITERAL, 0, 16'h0001), ins(OP_SUB, 2'b10, SRC_IMM, 0, 16'h0003),
      ins(OP_SUB, 2'b10, SRC_IMM, 0, 16'h0000), ins(OP_SWAP, 0, SRC_REG, 4'h7, 0),
      ins(OP_SWAP, 0, SRC_REG, 0, 0), ins(OP_SLEEP, 0, SRC_REG, 0, 0), ins(OP_SETIE, 0, SRC_REG, 0, 0),
      ins(OP_SLEEP, 0, SRC_REG, 0, 0)};
    run(0, 16'h0000);
    host.rd(ADDR_ACC_LO, got, rs);
    check("acc_lo", 32'h0000_FFFD, got);
    check("irq_enable", 32'h0, irq_enable);
    // a bus wake runs the set-enable parked behind the sleep, then sleeps again
    host.wr(ADDR_CTRL, 32'h0000_0003);
    repeat (5) @(posedge aclk);
    check("wake_irq_enable", 32'h1, irq_enable);
    check("sleeping_again", 32'h1, sleeping);
  endtask
  task automatic s_bits();
    pq = '{ins(OP_SHORT_LITERAL_LOAD_P, 0, SRC_SHORT_LITERAL, DR_X, 16'h0005), ins(OP_BSET, 2'b01, SRC_MEM, 0, 16'h0000),
      ins(OP_BCLR, 2'b01, SRC_MEM, 0, 16'h0004), ins(OP_BFLIP, 2'b01, SRC_MEM, 0, 16'h000F),
      ins(OP_REP, 0, SRC_IMM, 0, 16'h0002), ins(OP_BFLIP, 2'b01, SRC_MEM, 0, 16'h0001),
      ins(OP_BPROBE, 2'b01, SRC_MEM, 0, 16'h0003), ins(OP_SLEEP, 0, SRC_REG, 0, 0)};
    run(5, 16'h00F0);
    host.rd(XMEM_BASE + 13'h0014, got, rs);
    check("xmem_word", 32'h0000_80E3, got);
    host.rd(ADDR_STATUS, got, rs);
    check("probe_zero", 32'h1, got[ST_Z]);
  endtask
  task automatic s_mult();
    pq = '{ins(OP_SHORT_LITERAL_LOAD_A, 0, SRC_SHORT_LITERAL, 0, 16'h0001), ins(OP_MLD, 2'b10, SRC_MEM, 0, 0),
      ins(OP_MULT_ACCUMULATE, 2'b10, SRC_MEM, 0, 0), ins(OP_SLEEP, 0, SRC_REG, 0, 0)};
    run(0, 16'h4000);
    host.rd(ADDR_PROD, got, rs);
    check("product", 32'h2000_0000, got);
    host.rd(ADDR_ACC_HI, got, rs);
    check("mac_acc_hi", 32'h0000_2000, got);
  endtask
  // branch skips a set-enable; stack, direct load, shifts and a register repeat
  task automatic s_flow();
    pq = '{ins(OP_BRA, 0, SRC_REG, 0, 16'h0002), ins(OP_SETIE, 0, SRC_REG, 0, 0),
      ins(OP_PUSH, 0, SRC_IMM, 0, 16'h0003), ins(OP_POP, 0, SRC_REG, DR_EXP, 0),
      ins(OP_OR, 0, SRC_DRAM, 0, 16'h0000), ins(OP_BARREL_SHIFT_R, 0, SRC_REG, 0, 0),
      ins(OP_BARREL_SHIFT_I, 0, SRC_REG, 0, 16'h003F), ins(OP_REP, 0, SRC_REG, DR_EXP, 0),
      ins(OP_BARREL_SHIFT_I, 0, SRC_REG, 0, 16'h0001), ins(OP_SLEEP, 0, SRC_REG, 0, 0)};
    run(0, 16'h0001);
    host.rd(ADDR_ACC_HI, got, rs);
    check("flow_acc_hi", 32'h0000_0040, got);
    check("skipped_irq_enable", 32'h0, irq_enable);
  endtask

  // main sequence
  initial begin
    aresetn = 1'b0;
    err_count = 0;
    n_compared = 0;
    @(posedge aclk);
    s_acc();
    s_sub();
    s_bits();
    s_mult();
    s_flow();
    print_verdict();
  end
endmodule

// *** sim/dxe_axi_host.sv ***
// axi4-lite host model on the far side of the register bus
module dxe_axi_host (
  // clock
  input  wire logic        aclk,
  // requests
  output logic [12:0]      s_axi_awaddr, s_axi_araddr,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, hang,
  // answers
  input  wire logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp
);
  timeunit 1ns;
  timeprecision 1ns;
  // ready lines stay high so every answer is taken at once
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, hang} = '0;
    {s_axi_wstrb, s_axi_bready, s_axi_rready} = 6'h3F;
  end
  // released lines show the inverse so stale values never pass
  task automatic wr(input logic [12:0] a, input logic [31:0] d);
    {s_axi_awvalid, s_axi_awaddr, s_axi_wvalid, s_axi_wdata} <= {1'b1, a, 1'b1, d};
    repeat (40) begin
      @(posedge aclk);
      if (s_axi_awready) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
      if (s_axi_wready) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
      if (s_axi_bvalid) return;
    end
    hang <= 1'b1;
  endtask
  task automatic rd(input logic [12:0] a, output logic [31:0] d, output logic [1:0] r);
    {s_axi_arvalid, s_axi_araddr} <= {1'b1, a};
    repeat (40) begin
      @(posedge aclk);
      if (s_axi_arready) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
      if (s_axi_rvalid) begin
        {d, r} = {s_axi_rdata, s_axi_rresp};
        return;
      end
    end
    hang <= 1'b1;
  endtask
endmodule

// *** sim/dxe_core_properties.sv ***
// bus handshake and sleep properties of the execute core
module dxe_core_properties (
  // clock and reset
  input wire logic aclk, aresetn,
  // register bus handshakes
  input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready,
  input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
  // core state
  input wire logic sleeping
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // answers follow the handshakes by the stated cycle counts
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write answer not released");
  r_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read answer not released");
  // no new request while an answer is pending, and no write answer without a request
  wr_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during answer");
  rd_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during answer");
  b_cause_a: assert property ($rose(s_axi_bvalid) |-> $past(s_axi_awvalid, 2))
    else $error("write answer without request");
  // sleep only ends at the edge that raises a write answer
  sleep_hold_a: assert property (sleeping |=> sleeping || s_axi_bvalid)
    else $error("sleep left without wake");
  wr_seen_c: cover property (s_axi_bvalid && s_axi_bready);
  rd_seen_c: cover property (s_axi_rvalid && s_axi_rready);
  sleep_seen_c: cover property ($rose(sleeping));
endmodule

bind dxe_core dxe_core_properties u_prop (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .sleeping);
